// file: pkg/param_store_pkg.sv
// Purpose: Constants and types for the parameter category store
// Assumes: Object writes arrive as one-cycle strobes on the system clock
// Notes: Nonvolatile record = {valid, category, index, subindex, data}
package param_store_pkg;

  typedef enum logic [2:0] {
    CAT_NONE = 3'h0, CAT_COMM = 3'h1, CAT_APP = 3'h2, CAT_CUST = 3'h3,
    CAT_DRIVE = 3'h4, CAT_TUNE = 3'h5, CAT_CAN = 3'h6, CAT_MODBUS = 3'h7
  } cat_e;

  // Gray codes along load -> idle -> save, idle -> erase
  typedef enum logic [2:0] {
    ST_LOAD = 3'h0, ST_IDLE = 3'h1, ST_SAVE = 3'h3, ST_ERASE_RD = 3'h5, ST_ERASE_WR = 3'h4
  } state_e;

  localparam logic [15:0] STORE_IDX = 16'h1010;
  localparam logic [15:0] RESTORE_IDX = 16'h1011;
  localparam logic [31:0] SAVE_KEY = 32'h65766173;
  localparam logic [31:0] DISCARD_KEY = 32'h64616f6c;

  localparam logic [7:0] SUB_ALL = 8'h01;
  localparam logic [7:0] SUB_COMM = 8'h02;
  localparam logic [7:0] SUB_APP = 8'h03;
  localparam logic [7:0] SUB_CUST = 8'h04;
  localparam logic [7:0] SUB_DRIVE = 8'h05;
  localparam logic [7:0] SUB_TUNE = 8'h06;
  localparam logic [7:0] SUB_CAN = 8'h0a;
  localparam logic [7:0] SUB_MODBUS = 8'h0b;

  // Category masks, bit n = cat_e value n
  localparam logic [7:0] MASK_SAVE_ALL = 8'h3e;
  localparam logic [7:0] MASK_DISCARD_ALL = 8'h1e;

  // Customer category index window
  localparam logic [15:0] CUST_IDX_LO = 16'h2700;
  localparam logic [15:0] CUST_IDX_HI = 16'h27ff;

  localparam int SLOTS = 32;
  localparam int SLOT_W = 5;
  localparam logic [4:0] LAST_SLOT = 5'h1f;
  localparam logic [4:0] FIRST_SLOT = 5'h00;

  localparam int REC_W = 60;
  localparam int REC_VALID = 59;
  localparam int REC_CAT_LSB = 56;
  localparam int REC_IDX_LSB = 40;
  localparam int REC_SUB_LSB = 32;
  localparam logic [59:0] REC_EMPTY = 60'h0;

  localparam logic [11:0] DONE_RESET = 12'h000;

endpackage

// file: verilog/param_category_store.sv
// Purpose: Keeps storable object values by category, saves, discards and reloads them
// Assumes: Nonvolatile memory holds one record per slot and answers with a one-cycle ack
// Notes: Nonvolatile contents survive anything this block does except save and discard
module param_category_store
  import param_store_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  // Object writes from the master
  input wire logic odWrite,
  input wire logic [15:0] odIndex,
  input wire logic [7:0] odSub,
  input wire logic [31:0] odData,
  // Values handed to the control functions
  output logic applyValid,
  output logic [15:0] applyIndex,
  output logic [7:0] applySub,
  output logic [31:0] applyData,
  // Status
  output logic busy,
  output logic [11:0] storeDone,
  output logic refused,
  output logic tableFull,
  // Nonvolatile memory
  output logic nvmReq,
  output logic nvmWe,
  output logic [param_store_pkg::SLOT_W-1:0] nvmAddr,
  output logic [param_store_pkg::REC_W-1:0] nvmWdata,
  input wire logic [param_store_pkg::REC_W-1:0] nvmRdata,
  input wire logic nvmAck
);
  import param_store_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Category of an object index
  function automatic cat_e catOf(input logic [15:0] idx);
    cat_e c;
    c = CAT_NONE;
    case (idx)
      16'h1005, 16'h1006, 16'h1007, 16'h100c, 16'h100d, 16'h1014, 16'h1016, 16'h1017,
      16'h1019, 16'h1029: c = CAT_COMM;
      16'h1f80, 16'h2102, 16'h3502, 16'h3602: c = CAT_COMM;
      16'h2034, 16'h2035, 16'h2036, 16'h2037, 16'h2038: c = CAT_APP;
      16'h203a, 16'h203d, 16'h203e, 16'h203f, 16'h2057, 16'h2058, 16'h205b, 16'h2290,
      16'h2300, 16'h2410, 16'h3210, 16'h3212, 16'h3700, 16'h3701, 16'h4013: c = CAT_APP;
      16'h2084, 16'h2800: c = CAT_APP;
      16'h3240, 16'h3242, 16'h3243, 16'h3250, 16'h3252: c = CAT_APP;
      16'h3321, 16'h3322, 16'h3323: c = CAT_APP;
      16'h6040, 16'h605a, 16'h605b, 16'h605c, 16'h605d, 16'h605e, 16'h6060: c = CAT_APP;
      16'h6091, 16'h6092, 16'h60e8, 16'h60e9, 16'h60ed, 16'h60ee: c = CAT_APP;
      16'h6042, 16'h6046, 16'h6048, 16'h6049, 16'h604a, 16'h604c, 16'h6065, 16'h6066,
      16'h6067, 16'h6068, 16'h606d, 16'h606e, 16'h606f, 16'h6070, 16'h6071, 16'h6072,
      16'h607a, 16'h607b, 16'h607c, 16'h607d, 16'h607e, 16'h607f, 16'h6081, 16'h6082,
      16'h6083, 16'h6084, 16'h6085, 16'h6086, 16'h6087, 16'h6096, 16'h6097, 16'h6098,
      16'h6099, 16'h609a, 16'h60a2, 16'h60a4, 16'h60a8, 16'h60a9, 16'h60b0, 16'h60b1,
      16'h60b2, 16'h60c1, 16'h60c2, 16'h60c4, 16'h60c5, 16'h60c6, 16'h60f2, 16'h60f8,
      16'h60fe, 16'h60ff: c = CAT_APP;
      16'h3202, 16'h320d, 16'h320e, 16'h320f, 16'h6073, 16'h6080: c = CAT_DRIVE;
      16'h2030, 16'h2031, 16'h203b, 16'h3203, 16'h3380, 16'h3390, 16'h33a0, 16'h4021,
      16'h6075, 16'h608f, 16'h6090, 16'h60e6, 16'h60eb: c = CAT_TUNE;
      16'h2005, 16'h2007, 16'h2009: c = CAT_CAN;
      16'h2028, 16'h202a, 16'h202d: c = CAT_MODBUS;
      default: begin
        if (idx[15:4] == 12'h140 && !idx[3]) c = CAT_COMM;
        else if (idx[15:4] == 12'h160 && !idx[3]) c = CAT_COMM;
        else if (idx[15:4] == 12'h180 && !idx[3]) c = CAT_COMM;
        else if (idx[15:4] == 12'h1a0 && !idx[3]) c = CAT_COMM;
        else if (idx >= CUST_IDX_LO && idx <= CUST_IDX_HI) c = CAT_CUST;
        else c = CAT_NONE;
      end
    endcase
    return c;
  endfunction

  // Categories reached by a store or restore subindex
  function automatic logic [7:0] subMask(input logic [7:0] sub, input logic discard);
    logic [7:0] m;
    m = 8'h00;
    if (sub == SUB_ALL) m = discard ? MASK_DISCARD_ALL : MASK_SAVE_ALL;
    else if (sub == SUB_COMM) m[CAT_COMM] = 1'b1;
    else if (sub == SUB_APP) m[CAT_APP] = 1'b1;
    else if (sub == SUB_CUST) m[CAT_CUST] = 1'b1;
    else if (sub == SUB_DRIVE) m[CAT_DRIVE] = 1'b1;
    else if (sub == SUB_TUNE) m[CAT_TUNE] = 1'b1;
    else if (sub == SUB_CAN) m[CAT_CAN] = 1'b1;
    else if (sub == SUB_MODBUS) m[CAT_MODBUS] = 1'b1;
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rstMeta_ff, rstSync_ff;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else if (ce) begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end
  wire rstnInt = rstSync_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Working table
  logic [SLOTS-1:0] tblValid_ff;
  cat_e tblCat [SLOTS];
  logic [15:0] tblIdx [SLOTS];
  logic [7:0] tblSub [SLOTS];
  logic [31:0] tblData [SLOTS];

  state_e state_ff, nxt_state;
  logic [SLOT_W-1:0] ptr_ff, nxt_ptr;
  logic [7:0] mask_ff, nxt_mask;
  logic [3:0] doneSub_ff, nxt_doneSub;
  logic [11:0] storeDone_ff, nxt_done;
  logic nvmReq_ff, nxt_req, nvmWe_ff, nxt_we;
  logic [SLOT_W-1:0] nvmAddr_ff, nxt_addr;
  logic [REC_W-1:0] nvmWdata_ff, nxt_wdata;
  logic applyValid_ff, refused_ff, tableFull_ff, busy_ff;
  logic [15:0] applyIndex_ff;
  logic [7:0] applySub_ff;
  logic [31:0] applyData_ff;

  wire cat_e wrCat = catOf(odIndex);
  wire isIdle = state_ff == ST_IDLE;
  wire lastSlot = ptr_ff == LAST_SLOT;
  wire keyWrite = odWrite && (odIndex == STORE_IDX || odIndex == RESTORE_IDX);
  wire saveGo = isIdle && odWrite && odIndex == STORE_IDX && odData == SAVE_KEY
    && subMask(odSub, 1'b0) != 8'h00;
  wire discGo = isIdle && odWrite && odIndex == RESTORE_IDX && odData == DISCARD_KEY
    && subMask(odSub, 1'b1) != 8'h00;
  wire cat_e rdCat = cat_e'(nvmRdata[REC_CAT_LSB +: 3]);
  wire rdValid = nvmRdata[REC_VALID];
  wire cat_e ptrCat = tblCat[ptr_ff];
  wire slotSel = tblValid_ff[ptr_ff] && mask_ff[ptrCat];
  wire [REC_W-1:0] ptrRec = {1'b1, ptrCat, tblIdx[ptr_ff], tblSub[ptr_ff], tblData[ptr_ff]};
  wire ackNow = nvmReq_ff && nvmAck;

  // Slot search: matching entry first, else first free one
  logic hitAny, freeAny;
  logic [SLOT_W-1:0] hitSlot, freeSlot;
  always_comb begin
    hitAny = 1'b0;
    freeAny = 1'b0;
    hitSlot = FIRST_SLOT;
    freeSlot = FIRST_SLOT;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (tblValid_ff[i] && tblIdx[i] == odIndex && tblSub[i] == odSub) begin
        hitAny = 1'b1;
        hitSlot = SLOT_W'(i);
      end
      if (!tblValid_ff[i]) begin
        freeAny = 1'b1;
        freeSlot = SLOT_W'(i);
      end
    end
  end

  wire liveStore = isIdle && odWrite && wrCat != CAT_NONE && (hitAny || freeAny);
  wire [SLOT_W-1:0] liveSlot = hitAny ? hitSlot : freeSlot;
  wire liveApply = odWrite && wrCat != CAT_CUST && (wrCat == CAT_NONE || liveStore);
  wire loadWe = state_ff == ST_LOAD && ackNow && rdValid;
  wire loadApply = loadWe && rdCat != CAT_CUST;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_ptr = ptr_ff;
    nxt_mask = mask_ff;
    nxt_doneSub = doneSub_ff;
    nxt_done = storeDone_ff;
    nxt_req = nvmReq_ff;
    nxt_we = nvmWe_ff;
    nxt_addr = nvmAddr_ff;
    nxt_wdata = nvmWdata_ff;
    if (ackNow) nxt_req = 1'b0;
    case (state_ff)
      ST_LOAD: begin
        if (!nvmReq_ff) begin
          nxt_req = 1'b1;
          nxt_we = 1'b0;
          nxt_addr = ptr_ff;
        end else if (nvmAck) begin
          nxt_ptr = SLOT_W'(ptr_ff + 1'b1);
          if (lastSlot) nxt_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        nxt_ptr = FIRST_SLOT;
        if (saveGo) begin
          nxt_mask = subMask(odSub, 1'b0);
          nxt_doneSub = odSub[3:0];
          nxt_done[odSub[3:0]] = 1'b0;
          nxt_state = ST_SAVE;
        end else if (discGo) begin
          nxt_mask = subMask(odSub, 1'b1);
          nxt_state = ST_ERASE_RD;
        end
      end
      ST_SAVE: begin
        if (!nvmReq_ff && slotSel) begin
          nxt_req = 1'b1;
          nxt_we = 1'b1;
          nxt_addr = ptr_ff;
          nxt_wdata = ptrRec;
        end else if (ackNow || (!nvmReq_ff && !slotSel)) begin
          nxt_ptr = SLOT_W'(ptr_ff + 1'b1);
          if (lastSlot) begin
            nxt_state = ST_IDLE;
            nxt_done[doneSub_ff] = 1'b1;
          end
        end
      end
      ST_ERASE_RD: begin
        if (!nvmReq_ff) begin
          nxt_req = 1'b1;
          nxt_we = 1'b0;
          nxt_addr = ptr_ff;
        end else if (nvmAck) begin
          if (rdValid && mask_ff[rdCat]) nxt_state = ST_ERASE_WR;
          else begin
            nxt_ptr = SLOT_W'(ptr_ff + 1'b1);
            if (lastSlot) nxt_state = ST_IDLE;
          end
        end
      end
      ST_ERASE_WR: begin
        if (!nvmReq_ff) begin
          nxt_req = 1'b1;
          nxt_we = 1'b1;
          nxt_wdata = REC_EMPTY;
        end else if (nvmAck) begin
          nxt_ptr = SLOT_W'(ptr_ff + 1'b1);
          nxt_state = lastSlot ? ST_IDLE : ST_ERASE_RD;
        end
      end
      default: nxt_state = ST_LOAD;
    endcase
  end

  always_ff @(posedge clock or negedge rstnInt) begin
    if (!rstnInt) begin
      state_ff <= ST_LOAD;
      ptr_ff <= FIRST_SLOT;
      mask_ff <= 8'h00;
      doneSub_ff <= 4'h0;
      storeDone_ff <= DONE_RESET;
      nvmReq_ff <= 1'b0;
      nvmWe_ff <= 1'b0;
      nvmAddr_ff <= FIRST_SLOT;
      nvmWdata_ff <= REC_EMPTY;
      busy_ff <= 1'b1;
    end else if (ce) begin
      state_ff <= nxt_state;
      ptr_ff <= nxt_ptr;
      mask_ff <= nxt_mask;
      doneSub_ff <= nxt_doneSub;
      storeDone_ff <= nxt_done;
      nvmReq_ff <= nxt_req;
      nvmWe_ff <= nxt_we;
      nvmAddr_ff <= nxt_addr;
      nvmWdata_ff <= nxt_wdata;
      busy_ff <= nxt_state != ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table and forwarded values
  always_ff @(posedge clock or negedge rstnInt) begin
    if (!rstnInt) begin
      tblValid_ff <= '0;
    end else if (ce) begin
      if (loadWe) tblValid_ff[ptr_ff] <= 1'b1;
      else if (liveStore) tblValid_ff[liveSlot] <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (ce && loadWe) begin
      tblCat[ptr_ff] <= rdCat;
      tblIdx[ptr_ff] <= nvmRdata[REC_IDX_LSB +: 16];
      tblSub[ptr_ff] <= nvmRdata[REC_SUB_LSB +: 8];
      tblData[ptr_ff] <= nvmRdata[31:0];
    end else if (ce && liveStore) begin
      tblCat[liveSlot] <= wrCat;
      tblIdx[liveSlot] <= odIndex;
      tblSub[liveSlot] <= odSub;
      tblData[liveSlot] <= odData;
    end
  end

  always_ff @(posedge clock or negedge rstnInt) begin
    if (!rstnInt) begin
      applyValid_ff <= 1'b0;
      applyIndex_ff <= 16'h0000;
      applySub_ff <= 8'h00;
      applyData_ff <= 32'h00000000;
      refused_ff <= 1'b0;
      tableFull_ff <= 1'b0;
    end else if (ce) begin
      applyValid_ff <= loadApply || liveApply;
      if (loadApply) begin
        applyIndex_ff <= nvmRdata[REC_IDX_LSB +: 16];
        applySub_ff <= nvmRdata[REC_SUB_LSB +: 8];
        applyData_ff <= nvmRdata[31:0];
      end else if (liveApply) begin
        applyIndex_ff <= odIndex;
        applySub_ff <= odSub;
        applyData_ff <= odData;
      end
      refused_ff <= odWrite && !isIdle && (keyWrite || wrCat != CAT_NONE);
      tableFull_ff <= !freeAny;
    end
  end

  assign applyValid = applyValid_ff;
  assign applyIndex = applyIndex_ff;
  assign applySub = applySub_ff;
  assign applyData = applyData_ff;
  assign busy = busy_ff;
  assign storeDone = storeDone_ff;
  assign refused = refused_ff;
  assign tableFull = tableFull_ff;
  assign nvmReq = nvmReq_ff;
  assign nvmWe = nvmWe_ff;
  assign nvmAddr = nvmAddr_ff;
  assign nvmWdata = nvmWdata_ff;

endmodule // param_category_store

// file: verif/param_category_store_sva.sv
// Purpose: Port-level checks of the parameter category store
// Assumes: Single clock domain, rstn low disables checking
// Notes: Save mask tracked from the accepted trigger
module param_category_store_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  // Object writes
  input wire logic odWrite,
  input wire logic [15:0] odIndex,
  input wire logic [7:0] odSub,
  input wire logic [31:0] odData,
  // Block outputs
  input wire logic applyValid,
  input wire logic [15:0] applyIndex,
  input wire logic [31:0] applyData,
  input wire logic busy,
  input wire logic [11:0] storeDone,
  input wire logic refused,
  // Memory port
  input wire logic nvmReq,
  input wire logic nvmWe,
  input wire logic [param_store_pkg::REC_W-1:0] nvmWdata
);
  timeunit 1ns;
  timeprecision 100ps;
  import param_store_pkg::*;
  logic okSub;
  logic isTrig;
  logic [7:0] nxt_saveMask;
  logic [7:0] saveMask_ff;
  assign okSub = (odSub >= SUB_ALL && odSub <= SUB_TUNE) || odSub == SUB_CAN || odSub == SUB_MODBUS;
  assign isTrig = ce && odWrite && !busy && odIndex == STORE_IDX && odData == SAVE_KEY && okSub;
  assign nxt_saveMask = (odSub == SUB_ALL) ? MASK_SAVE_ALL : (odSub == SUB_CAN) ? 8'h40 :
                        (odSub == SUB_MODBUS) ? 8'h80 : 8'h01 << (odSub[2:0] - 3'h1);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) saveMask_ff <= 8'h00;
    else if (isTrig) saveMask_ff <= nxt_saveMask;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////
  trig_busy_a: assert property (isTrig |=> busy)
    else $error("accepted save did not raise busy");
  trig_clear_a: assert property (isTrig |=> storeDone[$past(odSub[3:0])] == 1'b0)
    else $error("done flag not cleared at save start");
  done_idle_a: assert property ((storeDone & ~$past(storeDone)) != 12'h000 |-> !busy && $past(busy))
    else $error("done flag set outside save completion");
  op_bound_a: assert property ($rose(busy) |-> ##[1:400] !busy)
    else $error("operation did not finish in time");
  busy_refuse_a: assert property (ce && odWrite && busy && (odIndex == STORE_IDX || odIndex == RESTORE_IDX)
    |=> refused)
    else $error("trigger while busy not refused");
  cust_hidden_a: assert property (ce && odWrite && odIndex >= CUST_IDX_LO && odIndex <= CUST_IDX_HI
    |=> !applyValid)
    else $error("customer value handed to control");
  apply_fwd_a: assert property (ce && odWrite && !busy && odIndex == 16'h6060
    |=> applyValid && applyIndex == 16'h6060 && applyData == $past(odData))
    else $error("mode write not forwarded");
  save_cat_a: assert property (nvmReq && nvmWe && nvmWdata[REC_VALID]
    |-> saveMask_ff[nvmWdata[58:56]])
    else $error("record written outside saved categories");
  erase_zero_a: assert property (nvmReq && nvmWe && !nvmWdata[REC_VALID] |-> nvmWdata == REC_EMPTY)
    else $error("discard wrote a non-empty record");
  cover property (isTrig && odSub == SUB_ALL);
  cover property (refused);
  cover property (nvmReq && nvmWe && !nvmWdata[REC_VALID]);
endmodule // param_category_store_sva

bind param_category_store param_category_store_sva u_sva (.clock(clock), .rstn(rstn), .ce(ce),
  .odWrite(odWrite), .odIndex(odIndex), .odSub(odSub), .odData(odData), .applyValid(applyValid),
  .applyIndex(applyIndex), .applyData(applyData), .busy(busy), .storeDone(storeDone), .refused(refused),
  .nvmReq(nvmReq), .nvmWe(nvmWe), .nvmWdata(nvmWdata));

// file: verif/nvm_model.sv
// Purpose: Nonvolatile record memory behind the store
// Assumes: Request level held until ack
// Notes: Contents survive reset; read bus shows garbage outside ack
module nvm_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Ack delay in cycles
  input wire logic [1:0] slow,
  // Memory port
  input wire logic nvmReq,
  input wire logic nvmWe,
  input wire logic [param_store_pkg::SLOT_W-1:0] nvmAddr,
  input wire logic [param_store_pkg::REC_W-1:0] nvmWdata,
  output logic [param_store_pkg::REC_W-1:0] nvmRdata,
  output logic nvmAck
);
  timeunit 1ns;
  timeprecision 100ps;
  import param_store_pkg::*;
  logic [REC_W-1:0] mem [SLOTS];
  logic [REC_W-1:0] rdq;
  logic [1:0] cnt;
  initial begin
    for (int i = 0; i < SLOTS; i++) mem[i] = REC_EMPTY;
    rdq = REC_EMPTY;
    cnt = 2'h0;
    nvmAck = 1'b0;
  end
  assign nvmRdata = nvmAck ? rdq : ~rdq;
  // Memory never cleared by reset
  always @(posedge clock) begin
    nvmAck <= 1'b0;
    if (!rstn) cnt <= 2'h0;
    else if (nvmReq && !nvmAck) begin
      if (cnt >= slow) begin
        nvmAck <= 1'b1;
        cnt <= 2'h0;
        if (nvmWe) mem[nvmAddr] <= nvmWdata;
        else rdq <= mem[nvmAddr];
      end else cnt <= cnt + 2'h1;
    end
  end
endmodule // nvm_model

// file: verif/param_category_store_tb.sv
// Purpose: Self-checking bench for the parameter category store
// Assumes: Memory side played by nvm_model
// Notes: Inputs change on the falling edge
`define CHK(name, exp, got) begin checksDone++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got); end end
module param_category_store_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import param_store_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic odWrite = 1'b0;
  logic [15:0] odIndex = 16'h0000;
  logic [7:0] odSub = 8'h00;
  logic [31:0] odData = 32'h0;
  logic applyValid, busy, refused, tableFull, nvmReq, nvmWe, nvmAck;
  logic [15:0] applyIndex;
  logic [7:0] applySub;
  logic [31:0] applyData;
  logic [11:0] storeDone;
  logic [SLOT_W-1:0] nvmAddr;
  logic [REC_W-1:0] nvmWdata, nvmRdata;
  logic [1:0] slow = 2'h0;
  logic seenReload = 1'b0;
  int miscompares = 0;
  int checksDone = 0;
  logic [15:0] tIdx [26] = '{16'h1005, 16'h1029, 16'h1407, 16'h1607, 16'h1800, 16'h1a07, 16'h1f80, 16'h2102,
    16'h3602, 16'h2034, 16'h2038, 16'h3252, 16'h3323, 16'h605a, 16'h6091, 16'h60ee, 16'h2084, 16'h2800,
    16'h3202, 16'h6073, 16'h6080, 16'h2030, 16'h2700, 16'h2005, 16'h2028, 16'h6041};
  cat_e tCat [26] = '{CAT_COMM, CAT_COMM, CAT_COMM, CAT_COMM, CAT_COMM, CAT_COMM, CAT_COMM, CAT_COMM,
    CAT_COMM, CAT_APP, CAT_APP, CAT_APP, CAT_APP, CAT_APP, CAT_APP, CAT_APP, CAT_APP, CAT_APP,
    CAT_DRIVE, CAT_DRIVE, CAT_DRIVE, CAT_TUNE, CAT_CUST, CAT_CAN, CAT_MODBUS, CAT_NONE};

  always #2.5 clock = ~clock;

  param_category_store DUT (.clock(clock), .rstn(rstn), .ce(ce), .odWrite(odWrite), .odIndex(odIndex),
    .odSub(odSub), .odData(odData), .applyValid(applyValid), .applyIndex(applyIndex), .applySub(applySub),
    .applyData(applyData), .busy(busy), .storeDone(storeDone), .refused(refused), .tableFull(tableFull),
    .nvmReq(nvmReq), .nvmWe(nvmWe), .nvmAddr(nvmAddr), .nvmWdata(nvmWdata), .nvmRdata(nvmRdata),
    .nvmAck(nvmAck));
  nvm_model nvm (.clock(clock), .rstn(rstn), .slow(slow), .nvmReq(nvmReq), .nvmWe(nvmWe),
    .nvmAddr(nvmAddr), .nvmWdata(nvmWdata), .nvmRdata(nvmRdata), .nvmAck(nvmAck));

  always @(posedge clock) begin
    if (applyValid === 1'b1 && applyIndex === 16'h6060 && applyData === 32'h5) seenReload <= 1'b1;
  end
  ////////////////////////////////////////////////////////////
  task automatic conclude();
    if (miscompares == 0 && checksDone > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic waitIdle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    `CHK("idle wait", 1'b1, n < 2000)
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] data);
    @(negedge clock);
    odWrite = 1'b1;
    odIndex = idx;
    odSub = sub;
    odData = data;
    @(negedge clock);
    odWrite = 1'b0;
  endtask
  task automatic doReset();
    rstn = 1'b0;
    repeat (10) @(negedge clock);
    rstn = 1'b1;
    repeat (2) @(negedge clock);
    waitIdle();
  endtask
  function automatic logic [2:0] findCat(input logic [15:0] idx);
    findCat = CAT_NONE;
    for (int i = 0; i < SLOTS; i++) begin
      if (nvm.mem[i][REC_VALID] && nvm.mem[i][55:40] == idx) findCat = nvm.mem[i][58:56];
    end
  endfunction
  ////////////////////////////////////////////////////////////
  task automatic tApply();
    wr(16'h6060, 8'h00, 32'h3);
    `CHK("apply valid", 1'b1, applyValid)
    `CHK("apply data", 32'h3, applyData)
    wr(16'h2700, 8'h01, 32'h77);
    `CHK("customer hidden", 1'b0, applyValid)
    wr(16'h6041, 8'h00, 32'h21);
    `CHK("status forwarded", 1'b1, applyValid)
    `CHK("status index", 16'h6041, applyIndex)
    `CHK("status sub", 8'h00, applySub)
  endtask
  task automatic tTable();
    logic [2:0] exp;
    slow = 2'h2;
    for (int i = 0; i < 26; i++) wr(tIdx[i], 8'h01, {16'h0, tIdx[i]});
    wr(STORE_IDX, SUB_ALL, SAVE_KEY);
    waitIdle();
    `CHK("save all done", 1'b1, storeDone[1])
    for (int i = 0; i < 26; i++) begin
      exp = (tCat[i] == CAT_CAN || tCat[i] == CAT_MODBUS) ? CAT_NONE : tCat[i];
      `CHK("category after save all", exp, findCat(tIdx[i]))
    end
    wr(STORE_IDX, SUB_CAN, SAVE_KEY);
    waitIdle();
    wr(STORE_IDX, SUB_MODBUS, SAVE_KEY);
    waitIdle();
    `CHK("fieldbus saves done", 2'h3, storeDone[11:10])
    for (int i = 0; i < 9; i++) `CHK("stored category", tCat[i], findCat(tIdx[i]))
    for (int i = 9; i < 26; i++) begin
      `CHK("stored category", tCat[i], findCat(tIdx[i]))
    end
    `CHK("table not full", 1'b0, tableFull)
    slow = 2'h0;
  endtask
  task automatic tRefuse();
    wr(STORE_IDX, SUB_COMM, SAVE_KEY);
    wr(STORE_IDX, SUB_CUST, SAVE_KEY);
    `CHK("second trigger refused", 1'b1, refused)
    wr(16'h6060, 8'h00, 32'h9);
    `CHK("busy write refused", 1'b1, refused)
    waitIdle();
    `CHK("first save done", 1'b1, storeDone[2])
    `CHK("refused save not done", 1'b0, storeDone[4])
    wr(STORE_IDX, SUB_CUST, 32'h0);
    `CHK("wrong key ignored", 1'b0, busy)
  endtask
  task automatic tReload();
    wr(16'h6060, 8'h00, 32'h5);
    wr(STORE_IDX, SUB_APP, SAVE_KEY);
    waitIdle();
    seenReload = 1'b0;
    doReset();
    `CHK("saved value reloaded", 1'b1, seenReload)
  endtask
  task automatic tDiscard();
    wr(RESTORE_IDX, SUB_APP, DISCARD_KEY);
    waitIdle();
    `CHK("app record erased", CAT_NONE, findCat(16'h6060))
    `CHK("comm record kept", CAT_COMM, findCat(16'h1005))
    seenReload = 1'b0;
    doReset();
    `CHK("erased value not reloaded", 1'b0, seenReload)
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    doReset();
    tApply();
    tTable();
    tRefuse();
    tReload();
    tDiscard();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    conclude();
  end
endmodule // param_category_store_tb
